// ==== core/add_instruction_datapath.v ====
// Four-phase execution datapath for the three add instructions.
//
// Summary of operation
// - Add-literal adds the 8-bit immediate to the accumulator, updating five flags.
// - Opcode 001001da adds accumulator and addressed memory byte, updating five flags.
// - Destination clear writes the accumulator; set writes the memory byte back.
// - Bank bit clear uses quick-access bank; set uses the bank select register.
// - Bank clear, extended set enabled, address up to 95 selects indexed offset.
// - Opcode 001000da adds accumulator, memory byte and carry, updating five flags.
// - Add-with-carry writes accumulator or memory byte per the destination bit.
`include "add_datapath_consts.vh"

module add_instruction_datapath #(
    parameter ADDR_WIDTH = 12
) (
    input wire MCLK,
    input wire RST,
    input wire INSTR_VALID,
    input wire [15:0] INSTR_WORD,
    input wire EXTENDED_EN,
    input wire [3:0] BANK_SELECT_REGISTER,
    input wire [ADDR_WIDTH-1:0] INDEX_BASE,
    input wire [7:0] MEM_RDATA,
    output wire INSTR_READY,
    output reg [ADDR_WIDTH-1:0] MEM_ADDR,
    output reg MEM_RD,
    output reg MEM_WR,
    output reg [7:0] MEM_WDATA,
    output reg [7:0] ACCUM,
    output reg [4:0] STATUS_FLAGS,
    output reg INSTR_DONE,
    output reg INSTR_ILLEGAL
);
    // Phase codes of the instruction cycle, one clock each.
    localparam [1:0] PH_DECODE = 2'b00;
    localparam [1:0] PH_READ = 2'b01;
    localparam [1:0] PH_COMPUTE = 2'b10;
    localparam [1:0] PH_WRITE = 2'b11;

    reg [1:0] phase;
    reg [1:0] next_phase;
    reg [15:0] instr;
    reg is_literal;
    reg use_carry;
    reg [7:0] operand;
    reg [ADDR_WIDTH-1:0] next_addr;
    wire [7:0] alu_sum;
    wire [4:0] alu_flags;
    wire carry_in;
    wire dest_file;
    wire bank_bit;
    wire [7:0] file_addr;
    wire offered;
    wire accept;
    wire indexed;
    wire write_accum;

    // Decode helpers, shared between the acceptance check and the word capture.
    function is_add_literal;
        input [15:0] w;
        begin
            is_add_literal = (w[15:8] == `OPC_ADD_LITERAL);
        end
    endfunction

    function is_add_carry;
        input [15:0] w;
        begin
            is_add_carry = (w[15:10] == `OPC_ADD_CARRY);
        end
    endfunction

    function is_add_file;
        input [15:0] w;
        begin
            is_add_file = (w[15:10] == `OPC_ADD_FILE) || is_add_carry(w);
        end
    endfunction

    // Zero-extends a 12-bit banked address to the width of the address bus.
    function [ADDR_WIDTH-1:0] widen;
        input [11:0] a;
        reg [ADDR_WIDTH+11:0] wide;
        begin
            wide = {{ADDR_WIDTH{1'b0}}, a};
            widen = wide[ADDR_WIDTH-1:0];
        end
    endfunction

    assign dest_file = instr[`FLD_DEST_BIT];
    assign bank_bit = instr[`FLD_BANK_BIT];
    assign file_addr = instr[7:0];
    assign carry_in = use_carry & STATUS_FLAGS[`FLAG_C];
    assign INSTR_READY = (phase == PH_DECODE);
    assign offered = INSTR_VALID && INSTR_READY;
    assign accept = offered && (is_add_literal(INSTR_WORD) || is_add_file(INSTR_WORD));
    // The extended set only reinterprets low quick-access addresses, never banked ones.
    assign indexed = !bank_bit && EXTENDED_EN && (file_addr <= `INDEXED_LIMIT);
    // Add-literal has no destination bit, so its sum always returns to the accumulator.
    assign write_accum = is_literal || !dest_file;

    add_alu u_alu (
        .a(ACCUM),
        .b(operand),
        .carry_in(carry_in),
        .sum(alu_sum),
        .flags(alu_flags)
    );

    // Effective address: indexed offset, quick-access bank halves, or the selected bank.
    always @* begin
        if (indexed) begin
            next_addr = INDEX_BASE + widen({4'h0, file_addr});
        end else if (!bank_bit && (file_addr < `ACCESS_SPLIT)) begin
            next_addr = widen({4'h0, file_addr});
        end else if (!bank_bit) begin
            next_addr = widen({`SFR_BANK, file_addr});
        end else begin
            next_addr = widen({BANK_SELECT_REGISTER, file_addr});
        end
    end

    // A taken add walks the four phases once and then returns to decode.
    always @* begin
        case (phase)
            PH_DECODE: begin
                if (accept) begin
                    next_phase = PH_READ;
                end else begin
                    next_phase = PH_DECODE;
                end
            end
            PH_READ: begin
                next_phase = PH_COMPUTE;
            end
            PH_COMPUTE: begin
                next_phase = PH_WRITE;
            end
            PH_WRITE: begin
                next_phase = PH_DECODE;
            end
            default: begin
                next_phase = PH_DECODE;
            end
        endcase
    end

    always @(posedge MCLK) begin
        if (RST) begin
            phase <= PH_DECODE;
        end else begin
            phase <= next_phase;
        end
    end

    // The word is latched only when taken, so a refused word leaves no trace.
    always @(posedge MCLK) begin
        if (RST) begin
            instr <= 16'h0000;
            is_literal <= 1'b0;
            use_carry <= 1'b0;
        end else if (accept) begin
            instr <= INSTR_WORD;
            is_literal <= is_add_literal(INSTR_WORD);
            use_carry <= is_add_carry(INSTR_WORD);
        end
    end

    always @(posedge MCLK) begin
        if (RST) begin
            operand <= 8'h00;
            MEM_ADDR <= {ADDR_WIDTH{1'b0}};
            MEM_RD <= 1'b0;
        end else begin
            MEM_RD <= 1'b0;
            if (phase == PH_READ) begin
                if (is_literal) begin
                    operand <= instr[7:0];
                end else begin
                    MEM_ADDR <= next_addr;
                    MEM_RD <= 1'b1;
                end
            end else if ((phase == PH_COMPUTE) && !is_literal) begin
                // Memory data arrive in the same clock as the read strobe.
                operand <= MEM_RDATA;
            end
        end
    end

    // Results land only in the write phase, so a following add-with-carry sees
    // the carry of the instruction before it.
    always @(posedge MCLK) begin
        if (RST) begin
            ACCUM <= 8'h00;
            STATUS_FLAGS <= 5'h00;
            MEM_WDATA <= 8'h00;
            MEM_WR <= 1'b0;
        end else begin
            MEM_WR <= 1'b0;
            if (phase == PH_WRITE) begin
                STATUS_FLAGS <= alu_flags;
                if (write_accum) begin
                    ACCUM <= alu_sum;
                end else begin
                    MEM_WDATA <= alu_sum;
                    MEM_WR <= 1'b1;
                end
            end
        end
    end

    always @(posedge MCLK) begin
        if (RST) begin
            INSTR_DONE <= 1'b0;
            INSTR_ILLEGAL <= 1'b0;
        end else begin
            INSTR_DONE <= (phase == PH_WRITE);
            // Other opcodes belong to other units and are flagged back.
            INSTR_ILLEGAL <= offered && !accept;
        end
    end
endmodule // add_instruction_datapath

// ==== core/add_datapath_consts.vh ====
// Opcodes, field positions, flag bit positions and address constants for the add datapath.
`ifndef ADD_DATAPATH_CONSTS_VH
`define ADD_DATAPATH_CONSTS_VH
`define OPC_ADD_LITERAL 8'h0F
`define OPC_ADD_FILE 6'h09
`define OPC_ADD_CARRY 6'h08
`define FLD_DEST_BIT 9
`define FLD_BANK_BIT 8
`define INDEXED_LIMIT 8'h5F
`define ACCESS_SPLIT 8'h60
`define SFR_BANK 4'hF
`define FLAG_C 0
`define FLAG_DC 1
`define FLAG_Z 2
`define FLAG_OV 3
`define FLAG_N 4
`endif

// ==== core/add_alu.v ====
// Eight-bit adder with carry-in that produces the five arithmetic flags.
`include "add_datapath_consts.vh"

module add_alu (
    input wire [7:0] a,
    input wire [7:0] b,
    input wire carry_in,
    output wire [7:0] sum,
    output wire [4:0] flags
);
    wire [8:0] full;
    wire [4:0] low;

    assign full = {1'b0, a} + {1'b0, b} + {8'h00, carry_in};
    assign low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, carry_in};
    assign sum = full[7:0];
    assign flags[`FLAG_C] = full[8];
    assign flags[`FLAG_DC] = low[4];
    assign flags[`FLAG_Z] = (full[7:0] == 8'h00);
    assign flags[`FLAG_OV] = (a[7] == b[7]) && (full[7] != a[7]);
    assign flags[`FLAG_N] = full[7];
endmodule // add_alu

// ==== tb/add_props.sv ====
// Port checker for the add datapath.
module add_props (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic INSTR_VALID,
    input wire logic INSTR_READY,
    input wire logic MEM_RD,
    input wire logic MEM_WR,
    input wire logic INSTR_DONE,
    input wire logic INSTR_ILLEGAL,
    input wire logic [15:0] INSTR_WORD
);
    timeunit 1ns;
    timeprecision 1ps;
    wire lit = INSTR_WORD[15:8] == 8'h0F;
    wire file = INSTR_WORD[15:11] == 5'h04;
    wire take = INSTR_VALID && INSTR_READY;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    a_take_to_done: assert property (take && (lit || file) |-> ##4 INSTR_DONE)
        else $error("done late");
    a_ready_busy: assert property (take && (lit || file) |=> !INSTR_READY [*3])
        else $error("ready early");
    a_done_pulse: assert property (INSTR_DONE |=> !INSTR_DONE) else $error("done long");
    a_rd_pulse: assert property (MEM_RD |=> !MEM_RD) else $error("read long");
    a_file_read: assert property (take && file |-> ##2 MEM_RD) else $error("no read");
    a_lit_no_wr: assert property (take && lit |-> ##4 !MEM_WR) else $error("lit wrote");
    a_wr_at_done: assert property (MEM_WR |-> INSTR_DONE) else $error("stray write");
    a_dest_bit: assert property (take && file |-> ##4 MEM_WR == $past(INSTR_WORD[9], 4))
        else $error("dest wrong");
    a_non_add: assert property (take && !lit && !file |=> INSTR_ILLEGAL)
        else $error("no illegal");
    cover property (take && lit);
    cover property (MEM_WR);
    cover property (INSTR_ILLEGAL);
endmodule // add_props

// ==== tb/mem_model.sv ====
// Data memory at the far side of the add datapath.
module mem_model (
    input wire logic MCLK,
    input wire logic MEM_RD,
    input wire logic MEM_WR,
    input wire logic [11:0] MEM_ADDR,
    input wire logic [7:0] MEM_WDATA,
    output logic [7:0] MEM_RDATA
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:4095];
    logic [7:0] last = 8'h00;
    // Outside a read the bus shows the inverse of the last byte, never a stale match.
    always_comb MEM_RDATA = MEM_RD ? mem[MEM_ADDR] : ~last;
    always @(posedge MCLK) begin
        if (MEM_RD) last <= mem[MEM_ADDR];
        if (MEM_WR) mem[MEM_ADDR] <= MEM_WDATA;
    end
endmodule // mem_model

// ==== tb/testbench.sv ====
// Self-checking bench for the add datapath.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic MCLK = 0, RST = 1, INSTR_VALID = 0, EXTENDED_EN = 0;
    logic [15:0] INSTR_WORD = 16'h0000;
    logic [3:0] BANK_SELECT_REGISTER = 4'h0;
    logic [11:0] INDEX_BASE = 12'h000;
    wire [7:0] MEM_RDATA, MEM_WDATA, ACCUM;
    wire [11:0] MEM_ADDR;
    wire [4:0] STATUS_FLAGS;
    wire INSTR_READY, MEM_RD, MEM_WR, INSTR_DONE, INSTR_ILLEGAL;
    int fail_count = 0, checks = 0, cyc = 0;
    always #10 MCLK = ~MCLK;
    add_instruction_datapath dut_u (.MCLK, .RST, .INSTR_VALID, .INSTR_WORD, .EXTENDED_EN,
        .BANK_SELECT_REGISTER, .INDEX_BASE, .MEM_RDATA, .INSTR_READY, .MEM_ADDR, .MEM_RD,
        .MEM_WR, .MEM_WDATA, .ACCUM, .STATUS_FLAGS, .INSTR_DONE, .INSTR_ILLEGAL);
    mem_model mem_u (.MCLK, .MEM_ADDR, .MEM_RD, .MEM_WR, .MEM_WDATA, .MEM_RDATA);
    task chk(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task close_out;
        if (fail_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task run(input logic [15:0] w, input logic [7:0] acc, input logic [4:0] fl);
        @(negedge MCLK);
        INSTR_WORD = w;
        INSTR_VALID = 1;
        @(negedge MCLK);
        INSTR_VALID = 0;
        repeat (3) @(negedge MCLK);
        chk(INSTR_DONE, 1);
        chk(ACCUM, acc);
        chk(STATUS_FLAGS, fl);
    endtask
    task t_literal;
        run(16'h0F10, 8'h10, 5'h00);
        run(16'h0F15, 8'h25, 5'h00);
        run(16'h0F5B, 8'h80, 5'h1A);
        run(16'h0F80, 8'h00, 5'h0D);
    endtask
    task t_bank_file;
        mem_u.mem[12'h3C2] = 8'hC2;
        BANK_SELECT_REGISTER = 4'h3;
        run(16'h25C2, 8'hC2, 5'h10);
        chk(MEM_ADDR, 12'h3C2);
        mem_u.mem[12'hF70] = 8'h80;
        run(16'h2270, 8'hC2, 5'h09);
        chk(MEM_ADDR, 12'hF70);
        chk(MEM_WDATA, 8'h42);
        @(negedge MCLK);
        chk(mem_u.mem[12'hF70], 8'h42);
        mem_u.mem[12'h005] = 8'h47;
        run(16'h2605, 8'hC2, 5'h01);
        chk(MEM_ADDR, 12'h005);
        @(negedge MCLK);
        chk(mem_u.mem[12'h005], 8'h09);
    endtask
    task t_indexed;
        EXTENDED_EN = 1;
        INDEX_BASE = 12'h200;
        mem_u.mem[12'h210] = 8'h02;
        mem_u.mem[12'hF60] = 8'h3B;
        run(16'h2010, 8'hC5, 5'h10);
        chk(MEM_ADDR, 12'h210);
        run(16'h2660, 8'hC5, 5'h07);
        chk(MEM_ADDR, 12'hF60);
        @(negedge MCLK);
        chk(mem_u.mem[12'hF60], 8'h00);
        mem_u.mem[12'h310] = 8'h0A;
        run(16'h2110, 8'hD0, 5'h12);
        chk(MEM_ADDR, 12'h310);
    endtask
    task t_illegal;
        @(negedge MCLK);
        INSTR_WORD = 16'h1400;
        INSTR_VALID = 1;
        @(negedge MCLK);
        INSTR_VALID = 0;
        chk(INSTR_ILLEGAL, 1);
        chk(INSTR_READY, 1);
    endtask
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            close_out;
        end
    end
    initial begin
        repeat (16) @(posedge MCLK);
        @(negedge MCLK);
        RST = 0;
        t_literal;
        t_bank_file;
        t_indexed;
        t_illegal;
        close_out;
    end
endmodule // testbench
bind add_instruction_datapath add_props props_u (.MCLK, .RST, .INSTR_VALID, .INSTR_READY,
    .MEM_RD, .MEM_WR, .INSTR_DONE, .INSTR_ILLEGAL, .INSTR_WORD);
